// [core/mcs_pkg.sv]
/*
 * package for the stream-out channel status block: register offsets,
 * status field positions, reset values and the engine state type.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package mcs_pkg;

    localparam logic [7:0] CONTROL_OFF    = 8'h00;
    localparam logic [7:0] STATUS_OFF     = 8'h04;
    localparam logic [7:0] TAIL_PTR_OFF   = 8'h08;
    localparam logic [7:0] LENGTH_OFF     = 8'h0C;
    localparam logic [7:0] IRQ_STATUS_OFF = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFF   = 8'h14;

    localparam int HALTED_BIT    = 0;
    localparam int IDLE_BIT      = 1;
    localparam int RSVD_BIT      = 2;
    localparam int GATHER_BIT    = 3;
    localparam int INT_ERR_BIT   = 4;
    localparam int RUN_STOP_BIT  = 0;

    localparam int EV_HALT       = 0;
    localparam int EV_IDLE       = 1;
    localparam int EV_ERR        = 2;
    localparam int EV_W          = 3;

    localparam logic HALTED_RST  = 1'b1;
    localparam logic IDLE_RST    = 1'b0;
    localparam logic ERR_RST     = 1'b0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic [EV_W-1:0] EV_RST = 3'h0;

    typedef enum logic [1:0] {
        MCS_HALTED   = 2'b00,
        MCS_RUNNING  = 2'b01,
        MCS_STOPPING = 2'b11,
        MCS_PAUSED   = 2'b10
    } mcs_state_e;

    // engine side inputs grouped together
    typedef struct packed {
        logic busy;
        logic sg_busy;
        logic done;
        logic fetch_at_tail;
        logic desc_valid;
        logic desc_len_zero;
    } mcs_engine_s;

    // requests handed to the engine
    typedef struct packed {
        logic start;
        logic stop;
    } mcs_cmd_s;

endpackage

// [core/mcs_channel_status.sv]
/*
 * status tracking of the memory-to-stream channel: halted, idle,
 * gather included and internal error flags, run/stop control and
 * start gating, all reached over an Avalon-MM slave with waitrequest.
 * assumes the engine reports busy, done, tail reach and fetched
 * descriptors synchronously to clk_i, and honours start and stop.
 */
`timescale 1ns/1ns

module mcs_channel_status #(
    parameter bit GATHER_INCLUDED = 1'b1
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic [7:0]          avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire logic [31:0]         avs_writedata_i,
    output logic [31:0]              avs_readdata_o,
    output logic                     avs_waitrequest_o,
    input  wire mcs_pkg::mcs_engine_s engine_i,
    output mcs_pkg::mcs_cmd_s        cmd_o,
    output logic [31:0]              tail_ptr_o,
    output logic [31:0]              length_o,
    output logic                     irq_o
);

    mcs_pkg::mcs_state_e  state_q;
    logic                 run_stop_q;
    logic                 halted_q;
    logic                 idle_q;
    logic                 int_err_q;
    logic                 first_done_q;
    logic                 ack_q;
    logic [31:0]          rdata_q;
    logic [31:0]          tail_q;
    logic [31:0]          len_q;
    logic [mcs_pkg::EV_W-1:0] ev_stat_q;
    logic [mcs_pkg::EV_W-1:0] ev_mask_q;
    logic [mcs_pkg::EV_W-1:0] ev_set;
    logic                 wr_acc;
    logic                 rd_acc;
    logic                 tail_wr;
    logic                 len_wr;
    logic                 start_req;
    logic                 err_evt;
    logic                 eng_quiet;
    logic [31:0]          status_word;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        return a == off;
    endfunction

    // one wait cycle per access keeps read data registered
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign wr_acc  = avs_write_i & ack_q;
    assign rd_acc  = avs_read_i & ack_q;
    assign tail_wr = wr_acc & hit(avs_address_i, mcs_pkg::TAIL_PTR_OFF);
    assign len_wr  = wr_acc & hit(avs_address_i, mcs_pkg::LENGTH_OFF);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
        end
    end

    assign err_evt = GATHER_INCLUDED & engine_i.desc_valid
                   & engine_i.desc_len_zero;

    assign eng_quiet = GATHER_INCLUDED ? ~engine_i.busy & ~engine_i.sg_busy
                                       : ~engine_i.busy;

    // writes only start work while running
    assign start_req = run_stop_q & ~halted_q & ~err_evt
                     & (GATHER_INCLUDED ? tail_wr : len_wr);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_stop_q <= 1'b0;
        end else if (err_evt) begin
            run_stop_q <= 1'b0;
        end else if (wr_acc
                     & hit(avs_address_i, mcs_pkg::CONTROL_OFF)) begin
            run_stop_q <= avs_writedata_i[mcs_pkg::RUN_STOP_BIT]
                        & ~int_err_q;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tail_q <= 32'h0000_0000;
            len_q  <= 32'h0000_0000;
        end else begin
            if (tail_wr) begin
                tail_q <= avs_writedata_i;
            end
            if (len_wr) begin
                len_q <= avs_writedata_i;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= mcs_pkg::MCS_HALTED;
        end else begin
            case (state_q)
                mcs_pkg::MCS_HALTED: begin
                    if (run_stop_q) begin
                        state_q <= mcs_pkg::MCS_RUNNING;
                    end
                end
                mcs_pkg::MCS_RUNNING: begin
                    if (!run_stop_q || err_evt) begin
                        state_q <= mcs_pkg::MCS_STOPPING;
                    end
                end
                mcs_pkg::MCS_STOPPING: begin
                    // halt lags until engine is quiet
                    if (eng_quiet) begin
                        state_q <= mcs_pkg::MCS_HALTED;
                    end
                end
                default: begin
                    state_q <= mcs_pkg::MCS_HALTED;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            halted_q <= mcs_pkg::HALTED_RST;
        end else begin
            // run/stop set again mid-stop skips the halt and resumes
            halted_q <= (state_q == mcs_pkg::MCS_STOPPING && eng_quiet
                         && !run_stop_q)
                      | (state_q == mcs_pkg::MCS_HALTED && !run_stop_q);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            first_done_q <= 1'b0;
        end else if (engine_i.done) begin
            first_done_q <= 1'b1;
        end
    end

    // idle follows descriptor/transfer progress, not data beats
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            idle_q <= mcs_pkg::IDLE_RST;
        end else if (halted_q || state_q != mcs_pkg::MCS_RUNNING) begin
            idle_q <= 1'b0;
        end else if (start_req) begin
            // tail write (length write in direct mode) resumes and clears idle
            idle_q <= 1'b0;
        end else if (GATHER_INCLUDED) begin
            // idle at tail with queue drained
            idle_q <= engine_i.fetch_at_tail & ~engine_i.sg_busy;
        end else begin
            // idle only after a finished transfer
            idle_q <= (first_done_q | engine_i.done) & ~engine_i.busy;
        end
    end

    // sticky error, only reset clears it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_err_q <= mcs_pkg::ERR_RST;
        end else if (err_evt) begin
            int_err_q <= 1'b1;
        end
    end

    assign cmd_o.start = start_req;
    assign cmd_o.stop  = state_q == mcs_pkg::MCS_STOPPING;
    assign tail_ptr_o  = tail_q;
    assign length_o    = len_q;

    // reserved reads zero, gather bit is the build value
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[mcs_pkg::HALTED_BIT]  = halted_q;
        status_word[mcs_pkg::IDLE_BIT]    = idle_q;
        status_word[mcs_pkg::RSVD_BIT]    = 1'b0;
        status_word[mcs_pkg::GATHER_BIT]  = GATHER_INCLUDED;
        status_word[mcs_pkg::INT_ERR_BIT] = int_err_q;
    end

    assign ev_set[mcs_pkg::EV_HALT] = halted_q == 1'b0
        && state_q == mcs_pkg::MCS_STOPPING && eng_quiet
        && !run_stop_q;
    assign ev_set[mcs_pkg::EV_IDLE] = 1'b0 == idle_q
        && state_q == mcs_pkg::MCS_RUNNING && GATHER_INCLUDED
        && engine_i.fetch_at_tail && !engine_i.sg_busy && !start_req;
    assign ev_set[mcs_pkg::EV_ERR]  = err_evt;

    // read clears, a fresh event in that cycle wins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ev_stat_q <= mcs_pkg::EV_RST;
        end else if (rd_acc
                     && hit(avs_address_i, mcs_pkg::IRQ_STATUS_OFF)) begin
            ev_stat_q <= ev_set;
        end else begin
            ev_stat_q <= ev_stat_q | ev_set;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ev_mask_q <= mcs_pkg::EV_RST;
        end else if (wr_acc
                     && hit(avs_address_i, mcs_pkg::IRQ_MASK_OFF)) begin
            ev_mask_q <= avs_writedata_i[mcs_pkg::EV_W-1:0];
        end
    end

    assign irq_o = |(ev_stat_q & ev_mask_q);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= mcs_pkg::RDATA_RST;
        end else if (avs_read_i && !ack_q) begin
            case (avs_address_i)
                mcs_pkg::CONTROL_OFF:
                    rdata_q <= {31'h0000_0000, run_stop_q};
                mcs_pkg::STATUS_OFF:
                    rdata_q <= status_word;
                mcs_pkg::TAIL_PTR_OFF:
                    rdata_q <= tail_q;
                mcs_pkg::LENGTH_OFF:
                    rdata_q <= len_q;
                mcs_pkg::IRQ_STATUS_OFF:
                    rdata_q <= {29'h0000_0000, ev_stat_q};
                mcs_pkg::IRQ_MASK_OFF:
                    rdata_q <= {29'h0000_0000, ev_mask_q};
                default:
                    rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata_o = rdata_q;

    sequence s_stop_req;
        state_q == mcs_pkg::MCS_RUNNING && !run_stop_q;
    endsequence

    sequence s_quiet;
        state_q == mcs_pkg::MCS_STOPPING && eng_quiet && !run_stop_q;
    endsequence

    // first cycle of a status read, when read data is captured
    sequence s_status_read;
        avs_read_i && !ack_q && avs_address_i == mcs_pkg::STATUS_OFF;
    endsequence

    a_halt_reset_one: assert property (@(posedge clk_i)
        $fell(rst_i) |-> halted_q)
        else $error("halted not one after reset");
    a_halt_after_quiet: assert property (@(posedge clk_i)
        disable iff (rst_i) s_quiet |=> halted_q)
        else $error("halted missing after shutdown");
    a_stop_to_halt: assert property (@(posedge clk_i)
        disable iff (rst_i) s_stop_req ##1 s_quiet |=> halted_q)
        else $error("stop did not halt");
    a_halt_needs_stop: assert property (@(posedge clk_i)
        disable iff (rst_i) $rose(halted_q) |-> $past(!run_stop_q))
        else $error("halted while running");
    a_no_start_halted: assert property (@(posedge clk_i)
        disable iff (rst_i) halted_q |-> !cmd_o.start)
        else $error("start while halted");
    a_no_len_start: assert property (@(posedge clk_i)
        disable iff (rst_i) (!run_stop_q) |-> !cmd_o.start)
        else $error("start while stopped");
    a_idle_clear_halt: assert property (@(posedge clk_i)
        disable iff (rst_i) halted_q |-> !idle_q)
        else $error("idle while halted");
    a_tail_clears_idle: assert property (@(posedge clk_i)
        disable iff (rst_i) cmd_o.start |=> !idle_q)
        else $error("idle kept after resume");
    a_rsvd_gather: assert property (@(posedge clk_i)
        disable iff (rst_i) !status_word[mcs_pkg::RSVD_BIT]
        && status_word[mcs_pkg::GATHER_BIT] == GATHER_INCLUDED)
        else $error("bad reserved or gather bit");
    a_err_sticky: assert property (@(posedge clk_i)
        disable iff (rst_i) int_err_q |=> int_err_q)
        else $error("error flag dropped");
    a_err_stops: assert property (@(posedge clk_i)
        disable iff (rst_i) err_evt |=> !run_stop_q ##1 !idle_q)
        else $error("error did not stop channel");
    a_direct_no_err: assert property (@(posedge clk_i)
        disable iff (rst_i) !GATHER_INCLUDED |-> !int_err_q)
        else $error("error set in direct mode");
    a_direct_first: assert property (@(posedge clk_i)
        disable iff (rst_i) (!GATHER_INCLUDED && !first_done_q
        && !engine_i.done) |=> !idle_q)
        else $error("idle before first transfer");

    a_halt_from_quiet: assert property (@(posedge clk_i)
        disable iff (rst_i) $rose(halted_q)
        |-> $past(eng_quiet) && !$past(run_stop_q))
        else $error("halted before engine quiet");

    a_idle_needs_run: assert property (@(posedge clk_i)
        disable iff (rst_i) idle_q
        |-> $past(state_q == mcs_pkg::MCS_RUNNING))
        else $error("idle outside running");

    a_start_one_cycle: assert property (@(posedge clk_i)
        disable iff (rst_i) cmd_o.start |=> !cmd_o.start)
        else $error("start longer than one cycle");

    // stop stands for the whole lag, so halted cannot be seen early
    a_stop_not_halted: assert property (@(posedge clk_i)
        disable iff (rst_i) cmd_o.stop |-> !halted_q)
        else $error("halted while stop pending");

    a_err_blocks_run: assert property (@(posedge clk_i)
        disable iff (rst_i) int_err_q |-> !run_stop_q)
        else $error("run set with error pending");

    a_direct_idle_done: assert property (@(posedge clk_i)
        disable iff (rst_i) !GATHER_INCLUDED && idle_q |-> first_done_q)
        else $error("direct idle without transfer");

    a_gather_idle_tail: assert property (@(posedge clk_i)
        disable iff (rst_i) GATHER_INCLUDED && $rose(idle_q)
        |-> $past(engine_i.fetch_at_tail))
        else $error("idle before tail reached");

    a_status_fixed_bits: assert property (@(posedge clk_i)
        disable iff (rst_i) s_status_read |=> !avs_readdata_o[2]
        && avs_readdata_o[3] == GATHER_INCLUDED)
        else $error("bad fixed status bits read");

    a_status_halt_bit: assert property (@(posedge clk_i)
        disable iff (rst_i) s_status_read
        |=> avs_readdata_o[0] == $past(halted_q))
        else $error("halted bit read wrong");

endmodule

// [verification/tb_mcs_channel_status.sv]
/*
 * self-checking bench for the stream-out channel status block, with one
 * gather-mode and one direct-mode instance sharing bus and engine inputs.
 * assumes the package and the design module are compiled first.
 */
`timescale 1ns/1ns

module tb_mcs_channel_status;
    logic                  clk_i;
    logic                  rst_i;
    logic [7:0]            addr;
    logic                  rd;
    logic                  wr;
    logic [31:0]           wdata;
    logic [31:0]           rdata_g;
    logic [31:0]           rdata_d;
    logic                  wrq_g;
    logic                  irq_g;
    logic [31:0]           tail_g;
    logic [31:0]           len_d;
    mcs_pkg::mcs_engine_s  eng;
    mcs_pkg::mcs_cmd_s     cmd_g;
    mcs_pkg::mcs_cmd_s     cmd_d;
    int                    miscompares;
    int                    compares;
    int                    starts_g;
    int                    starts_d;
    int                    cyc;
    logic [31:0]           rg;
    logic [31:0]           rdd;

    typedef struct {
        logic        we;
        logic [7:0]  a;
        logic [31:0] wd;
        logic [31:0] eg;
        logic [31:0] ed;
    } mcs_row_s;

    mcs_row_s rows[7];

    mcs_channel_status #(.GATHER_INCLUDED(1'b1)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata_g), .avs_waitrequest_o(wrq_g),
        .engine_i(eng), .cmd_o(cmd_g), .tail_ptr_o(tail_g),
        .length_o(), .irq_o(irq_g));

    mcs_channel_status #(.GATHER_INCLUDED(1'b0)) dut_d (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata_d), .avs_waitrequest_o(),
        .engine_i(eng), .cmd_o(cmd_d), .tail_ptr_o(),
        .length_o(len_d), .irq_o());

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // start is a one-cycle comb pulse, so count it away from the edge
    always @(negedge clk_i) begin
        if (cmd_g.start === 1'b1) starts_g++;
        if (cmd_d.start === 1'b1) starts_d++;
    end

    task automatic conclude;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ceiling well above the hundred or so cycles the tests need
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        wr    <= we;
        rd    <= ~we;
        addr  <= a;
        wdata <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wrq_g !== 1'b0 && n < 50);
        if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
        rg  = rdata_g;
        rdd = rdata_d;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic poll_halt;
        for (int i = 0; i < 20; i++) begin
            bus(1'b0, mcs_pkg::STATUS_OFF, 32'h0);
            if (rg[0] === 1'b1) break;
        end
    endtask

    task automatic pulse_done;
        @(posedge clk_i);
        eng.done <= 1'b1;
        @(posedge clk_i);
        eng.done <= 1'b0;
    endtask

    initial begin
        rst_i = 1'b1;
        addr = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        eng = '0;
        rows[0] = '{1'b0, 8'h04, 32'h0, 32'h9, 32'h1};
        rows[1] = '{1'b1, 8'h04, 32'hFFFFFFFF, 32'h0, 32'h0};
        rows[2] = '{1'b0, 8'h04, 32'h0, 32'h9, 32'h1};
        rows[3] = '{1'b1, 8'h20, 32'hFFFFFFFF, 32'h0, 32'h0};
        rows[4] = '{1'b0, 8'h20, 32'h0, 32'h0, 32'h0};
        rows[5] = '{1'b1, 8'h08, 32'h00000040, 32'h0, 32'h0};
        rows[6] = '{1'b1, 8'h0C, 32'h00000100, 32'h0, 32'h0};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i].we, rows[i].a, rows[i].wd);
            if (!rows[i].we) begin
                chk("row gather", rows[i].eg, rg);
                chk("row direct", rows[i].ed, rdd);
            end
        end
        chk("halted starts", 32'h0, 32'(starts_g + starts_d));
        @(negedge clk_i);
        chk("tail value", 32'h40, tail_g);
        bus(1'b1, mcs_pkg::CONTROL_OFF, 32'h1);
        bus(1'b0, mcs_pkg::STATUS_OFF, 32'h0);
        chk("running direct", 32'h0, rdd);
        chk("running gather", 32'h8, rg);
        bus(1'b1, mcs_pkg::LENGTH_OFF, 32'h200);
        chk("length start", 32'h1, 32'(starts_d));
        @(negedge clk_i);
        chk("length value", 32'h200, len_d);
        pulse_done();
        eng.fetch_at_tail <= 1'b1;
        bus(1'b0, mcs_pkg::STATUS_OFF, 32'h0);
        chk("idle direct", 32'h2, rdd);
        chk("idle gather", 32'hA, rg);
        starts_g = 0;
        bus(1'b1, mcs_pkg::TAIL_PTR_OFF, 32'h80);
        chk("tail resume", 32'h1, 32'(starts_g));
        eng.fetch_at_tail <= 1'b0;
        eng.busy <= 1'b1;
        eng.sg_busy <= 1'b1;
        bus(1'b1, mcs_pkg::CONTROL_OFF, 32'h0);
        bus(1'b0, mcs_pkg::STATUS_OFF, 32'h0);
        chk("halt lag", 32'h0, 32'(rg[0]));
        chk("stop level", 32'h1, 32'(cmd_g.stop));
        eng.busy <= 1'b0;
        bus(1'b0, mcs_pkg::STATUS_OFF, 32'h0);
        chk("sg busy holds", 32'h0, 32'(rg[0]));
        eng.sg_busy <= 1'b0;
        poll_halt();
        chk("halted gather", 32'h9, rg);
        chk("halted direct", 32'h1, rdd);
        bus(1'b1, mcs_pkg::CONTROL_OFF, 32'h1);
        bus(1'b0, mcs_pkg::STATUS_OFF, 32'h0);
        @(posedge clk_i);
        eng.desc_valid <= 1'b1;
        eng.desc_len_zero <= 1'b1;
        @(posedge clk_i);
        eng.desc_valid <= 1'b0;
        eng.desc_len_zero <= 1'b0;
        poll_halt();
        chk("error gather", 32'h19, rg);
        chk("error direct", 32'h0, rdd & 32'h10);
        bus(1'b0, mcs_pkg::CONTROL_OFF, 32'h0);
        chk("run cleared", 32'h0, rg & 32'h1);
        bus(1'b1, mcs_pkg::CONTROL_OFF, 32'h1);
        bus(1'b0, mcs_pkg::STATUS_OFF, 32'h0);
        chk("error sticky", 32'h19, rg);
        bus(1'b1, mcs_pkg::IRQ_MASK_OFF, 32'h4);
        @(negedge clk_i);
        chk("irq raised", 32'h1, 32'(irq_g));
        bus(1'b0, mcs_pkg::IRQ_STATUS_OFF, 32'h0);
        chk("irq error bit", 32'h4, rg & 32'h4);
        @(negedge clk_i);
        chk("irq cleared", 32'h0, 32'(irq_g));
        // second reset while halted with the error set must drop the sticky error
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, mcs_pkg::STATUS_OFF, 32'h0);
        chk("reset gather", 32'h9, rg);
        conclude();
    end
endmodule
